// ==== ictrm_map.vh ====
// Offsets, field layout, reset values and frame layout of the I-channel trim bank
`ifndef ICTRM_MAP_VH
`define ICTRM_MAP_VH

`define ICTRM_ADDR_W         4
`define ICTRM_DATA_W         16
`define ICTRM_OFFSET_ADDR    4'h2
`define ICTRM_RANGE_ADDR     4'h3
`define ICTRM_OFFSET_RESET   16'h0000
`define ICTRM_RANGE_RESET    16'h4000
`define ICTRM_OFFSET_MASK    16'h1fff
`define ICTRM_RANGE_MASK     16'h7fff
`define ICTRM_SIGN_BIT       12
`define ICTRM_MAG_MSB        11
`define ICTRM_RANGE_MSB      14
`define ICTRM_RANGE_BASE     15'h4000
`define ICTRM_MONO_BITS      9
`define ICTRM_HDR_BITS       5'h08
`define ICTRM_FRAME_BITS     5'h18
`define ICTRM_RW_BIT         7

`endif

// ==== ictrm_regs.v ====
// I-channel offset and full-scale range trim registers behind a serial port
`timescale 1ns/1ps
`include "ictrm_map.vh"

module ictrm_regs (
	// Clock and reset
	input  wire        clk_sys_i,
	input  wire        rst_i,
	// Serial configuration port
	input  wire        scs_n_i,
	input  wire        sclk_i,
	input  wire        sdi_i,
	output reg         sdo_o,
	output reg         sdo_oe_o,
	// Trim outputs
	output reg         offset_sign_bit_o,
	output reg  [11:0] offset_magnitude_field_o,
	output reg  [12:0] offset_signed_o,
	output reg  [14:0] range_magnitude_field_o,
	output reg  [13:0] full_scale_range_step_o,
	output reg  [8:0]  range_monotonic_o
);

	reg  [2:0]  scs_sync_r;
	reg  [2:0]  sclk_sync_r;
	reg  [2:0]  sdi_sync_r;
	reg         scs_n_r;
	reg         sclk_r;
	reg         sdi_r;
	reg  [4:0]  bit_cnt_r;
	reg  [23:0] shift_r;
	reg  [15:0] out_r;
	reg         rd_r;
	reg  [15:0] offset_r;
	reg  [15:0] range_r;
	wire        sclk_rise;
	wire        sclk_fall;
	wire [4:0]  bit_cnt_nxt;
	wire [23:0] shift_nxt;

	// Unmapped addresses read as zero
	function [15:0] ictrm_read;
		input [3:0] addr;
		begin
			if (addr == `ICTRM_OFFSET_ADDR) begin
				ictrm_read = offset_r;
			end else if (addr == `ICTRM_RANGE_ADDR) begin
				ictrm_read = range_r;
			end else begin
				ictrm_read = 16'h0000;
			end
		end
	endfunction

	// Pins pass three flops; a level is taken once the last two agree
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			scs_sync_r  <= 3'b111;
			sclk_sync_r <= 3'b000;
			sdi_sync_r  <= 3'b000;
			scs_n_r     <= 1'b1;
			sclk_r      <= 1'b0;
			sdi_r       <= 1'b0;
		end else begin
			scs_sync_r  <= {scs_sync_r[1:0], scs_n_i};
			sclk_sync_r <= {sclk_sync_r[1:0], sclk_i};
			sdi_sync_r  <= {sdi_sync_r[1:0], sdi_i};
			if (scs_sync_r[1] == scs_sync_r[2]) begin
				scs_n_r <= scs_sync_r[2];
			end
			if (sclk_sync_r[1] == sclk_sync_r[2]) begin
				sclk_r <= sclk_sync_r[2];
			end
			if (sdi_sync_r[1] == sdi_sync_r[2]) begin
				sdi_r <= sdi_sync_r[2];
			end
		end
	end

	assign sclk_rise   = !scs_n_r && sclk_sync_r[1] && sclk_sync_r[2] && !sclk_r;
	assign sclk_fall   = !scs_n_r && !sclk_sync_r[1] && !sclk_sync_r[2] && sclk_r;
	assign bit_cnt_nxt = bit_cnt_r + 5'h01;
	assign shift_nxt   = {shift_r[22:0], sdi_r};

	// Frame: 8 header bits (bit 7 read, bits 3:0 address), then 16 data bits
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			bit_cnt_r <= 5'h00;
			shift_r   <= 24'h00_0000;
			out_r     <= 16'h0000;
			rd_r      <= 1'b0;
			sdo_o     <= 1'b0;
			sdo_oe_o  <= 1'b0;
			offset_r  <= `ICTRM_OFFSET_RESET;
			range_r   <= `ICTRM_RANGE_RESET;
		end else if (scs_n_r) begin
			bit_cnt_r <= 5'h00;
			rd_r      <= 1'b0;
			sdo_oe_o  <= 1'b0;
		end else begin
			if (sclk_rise && bit_cnt_r != `ICTRM_FRAME_BITS) begin
				bit_cnt_r <= bit_cnt_nxt;
				shift_r   <= shift_nxt;
				if (bit_cnt_nxt == `ICTRM_HDR_BITS) begin
					rd_r  <= shift_nxt[`ICTRM_RW_BIT];
					out_r <= ictrm_read(shift_nxt[3:0]);
				end
				// Reserved bits are stored as zero whatever the host sends
				if (bit_cnt_nxt == `ICTRM_FRAME_BITS && !rd_r) begin
					if (shift_nxt[19:16] == `ICTRM_OFFSET_ADDR) begin
						offset_r <= shift_nxt[15:0] & `ICTRM_OFFSET_MASK;
					end else if (shift_nxt[19:16] == `ICTRM_RANGE_ADDR) begin
						range_r <= shift_nxt[15:0] & `ICTRM_RANGE_MASK;
					end
				end
			end
			// Read data shifts out on falling edges so it is stable at the rise
			if (sclk_fall && rd_r && bit_cnt_r != `ICTRM_FRAME_BITS) begin
				sdo_o    <= out_r[15];
				out_r    <= {out_r[14:0], 1'b0};
				sdo_oe_o <= 1'b1;
			end
		end
	end

	// Decoded trim values, registered so every output comes from a flop
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			offset_sign_bit_o        <= 1'b0;
			offset_magnitude_field_o <= 12'h000;
			offset_signed_o          <= 13'h0000;
			range_magnitude_field_o  <= 15'h4000;
			full_scale_range_step_o  <= 14'h0000;
			range_monotonic_o        <= 9'h100;
		end else begin
			offset_sign_bit_o        <= offset_r[`ICTRM_SIGN_BIT];
			offset_magnitude_field_o <= offset_r[`ICTRM_MAG_MSB:0];
			if (offset_r[`ICTRM_SIGN_BIT]) begin
				offset_signed_o <= 13'h0000 - {1'b0, offset_r[11:0]};
			end else begin
				offset_signed_o <= {1'b0, offset_r[11:0]};
			end
			range_magnitude_field_o <= range_r[`ICTRM_RANGE_MSB:0];
			// Codes under the 800 mV base clamp to the bottom of the range
			if (range_r[14]) begin
				full_scale_range_step_o <= range_r[13:0];
			end else begin
				full_scale_range_step_o <= 14'h0000;
			end
			// Lower bits give no monotonic guarantee, so expose the coarse part
			range_monotonic_o <= range_r[14:6];
		end
	end

endmodule // ictrm_regs

// ==== ictrm_checker.sv ====
// Assertions on the I-channel trim outputs
`timescale 1ns/1ps
module ictrm_checker (
	input wire        clk_sys_i,
	input wire        rst_i,
	input wire        offset_sign_bit_o,
	input wire [11:0] offset_magnitude_field_o,
	input wire [12:0] offset_signed_o,
	input wire [14:0] range_magnitude_field_o,
	input wire [13:0] full_scale_range_step_o,
	input wire [8:0]  range_monotonic_o
);
	wire [12:0] mag_w = {1'b0, offset_magnitude_field_o};
	wire [14:0] rng_w = range_magnitude_field_o;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	a_pos_offset: assert property (!offset_sign_bit_o |->
		offset_signed_o == mag_w) else $error("positive offset wrong");
	a_neg_offset: assert property (offset_sign_bit_o |->
		offset_signed_o == -mag_w) else $error("negative offset wrong");
	a_mag_follow: assert property ($changed(mag_w) |->
		$changed(offset_signed_o)) else $error("magnitude not applied");
	a_range_step: assert property (full_scale_range_step_o ==
		(rng_w[14] ? rng_w[13:0] : 14'h0000)) else $error("range step wrong");
	a_range_reset: assert property ($fell(rst_i) |->
		rng_w == 15'h4000) else $error("range reset wrong");
	a_mono_bits: assert property (range_monotonic_o ==
		rng_w[14:6]) else $error("monotonic bits wrong");
endmodule // ictrm_checker

bind ictrm_regs ictrm_checker u_chk (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
	.offset_sign_bit_o(offset_sign_bit_o),
	.offset_magnitude_field_o(offset_magnitude_field_o),
	.offset_signed_o(offset_signed_o),
	.range_magnitude_field_o(range_magnitude_field_o),
	.full_scale_range_step_o(full_scale_range_step_o),
	.range_monotonic_o(range_monotonic_o));

// ==== ictrm_regs_bench.sv ====
// Bench for the I-channel trim register bank
`timescale 1ns/1ps
`include "ictrm_map.vh"
module ictrm_regs_bench;
	reg clk_sys_i = 0, rst_i = 1, scs_n_i = 1, sclk_i = 0, sdi_i = 0;
	wire sdo_o, oe, osb;
	wire [11:0] omf;
	wire [12:0] osg;
	wire [14:0] rmf;
	wire [13:0] full_scale_range;
	wire [8:0] mono;
	integer seed = 43, miscompares = 0, n_checks = 0, cyc = 0, i, k;
	reg [15:0] rd_q[$], rd_v, d, e;
	reg [23:0] f;
	event got;
	ictrm_regs u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .scs_n_i(scs_n_i),
		.sclk_i(sclk_i), .sdi_i(sdi_i), .sdo_o(sdo_o), .sdo_oe_o(oe),
		.offset_sign_bit_o(osb), .offset_magnitude_field_o(omf),
		.offset_signed_o(osg), .range_magnitude_field_o(rmf),
		.full_scale_range_step_o(full_scale_range), .range_monotonic_o(mono));
	always #10 clk_sys_i = ~clk_sys_i;
	task check(input [15:0] seen, input [15:0] exp); begin
		n_checks = n_checks + 1;
		if (seen !== exp) begin
			miscompares = miscompares + 1;
			$display("Error %0t seen %h expected %h", $time, seen, exp);
		end
	end endtask
	task stop_test; begin
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	end endtask
	// Phases of 6 clocks leave margin over the 3-flop pin synchroniser
	task frame(input rd, input [3:0] a, input [15:0] v); begin
		f = {rd, 3'b000, a, v};
		scs_n_i = 0;
		for (i = 23; i >= 0; i = i - 1) begin
			sdi_i = f[i];
			repeat (6) @(negedge clk_sys_i);
			sclk_i = 1;
			repeat (6) @(negedge clk_sys_i);
			if (i < 16) rd_v[i] = sdo_o;
			sclk_i = 0;
		end
		repeat (6) @(negedge clk_sys_i);
		scs_n_i = 1;
		repeat (8) @(negedge clk_sys_i);
		if (rd) ->got;
	end endtask
	task rd(input [3:0] a, input [15:0] exp); begin
		rd_q.push_back(exp);
		frame(1, a, 16'h0000);
	end endtask
	always @(got) check(rd_v, rd_q.pop_front());
	always @(posedge clk_sys_i) begin
		cyc = cyc + 1;
		if (cyc == 30000) begin
			miscompares = miscompares + 1;
			stop_test;
		end
	end
	initial begin
		repeat (8) @(negedge clk_sys_i);
		rst_i = 0;
		repeat (6) @(negedge clk_sys_i);
		rd(4'h2, `ICTRM_OFFSET_RESET);
		rd(4'h3, `ICTRM_RANGE_RESET);
		rd(4'h5, 16'h0000);
		for (k = 0; k < 12; k = k + 1) begin
			// Reserved bits kept zero as the host must
			d = $random(seed) & `ICTRM_OFFSET_MASK;
			e = $random(seed) & `ICTRM_RANGE_MASK;
			if (k < 4) d = {3'b000, k[0], {12{k[1]}}};
			if (k == 0) e = 16'h7fff;
			frame(0, 4'h2, d);
			check({3'b000, osb, omf}, d);
			check({3'b000, osg}, d[12] ? {3'b000, 13'h0000 - {1'b0, d[11:0]}}
				: {4'h0, d[11:0]});
			check({15'h0000, oe}, 16'h0000);
			rd(4'h2, d);
			frame(0, 4'h3, e);
			check({1'b0, rmf}, e);
			check({2'b00, full_scale_range}, e[14] ? {2'b00, e[13:0]} : 16'h0000);
			check({7'h00, mono}, {7'h00, e[14:6]});
			rd(4'h3, e);
		end
		frame(0, 4'h5, 16'hffff);
		rd(4'h5, 16'h0000);
		rd(4'h2, d);
		repeat (4) @(negedge clk_sys_i);
		stop_test;
	end
endmodule // ictrm_regs_bench
